// file: sim/debug_host_pod.sv
/* Debug host pod model: starts every bit with a falling edge on the pin.
   Assumes the bench resolves the wire with a pull-up and sets div. */
`timescale 1ns/1ps
`default_nettype none

module debug_host_pod (
	input  wire logic clk,
	input  wire logic pin,
	output logic      hostOe,
	output logic      hostOut
);
	int div = 1; // bus clocks per link tick

	// pod starts off the pin
	initial begin
		hostOe = 1'b0;
		hostOut = 1'b1;
	end

	task automatic ticks(input int n);
		repeat (n * div) @(posedge clk);
	endtask : ticks

	task automatic drive(input logic oe, input logic lvl);
		hostOe <= oe;
		hostOut <= lvl;
	endtask : drive

	// falling edge opens a seventeen tick bit
	task automatic send_bit(input logic b);
		drive(1'b1, 1'b0);
		ticks(b ? 4 : 13);
		drive(1'b1, 1'b1); // driven rising edge
		ticks(b ? 12 : 3);
		drive(1'b0, 1'b1);
		ticks(1);
	endtask : send_bit

	task automatic send_byte(input logic [7:0] v);
		for (int i = 7; i >= 0; i--) send_bit(v[i]);
	endtask : send_byte

	task automatic send_word(input logic [31:0] v);
		for (int i = 3; i >= 0; i--) send_byte(v[i*8 +: 8]);
	endtask : send_word

	// short low, release, sample near tick ten
	task automatic recv_bit(output logic b);
		drive(1'b1, 1'b0);
		ticks(2);
		drive(1'b0, 1'b1);
		ticks(8);
		b = pin;
		ticks(7);
	endtask : recv_bit

	task automatic recv_byte(output logic [7:0] v);
		for (int i = 7; i >= 0; i--) recv_bit(v[i]);
	endtask : recv_byte
endmodule : debug_host_pod

`default_nettype wire

// file: sim/single_wire_debug_link_properties.sv
/* Port checker for single_wire_debug_link, bound onto it below.
   Assumes one clock, synchronous active-high reset and the package map. */
`timescale 1ns/1ps
`default_nettype none

module single_wire_debug_link_properties #(
	parameter int unsigned ALT_DIV    = 4,
	parameter int unsigned HALT_SRC_N = 3
) (
	input wire logic                  clk,
	input wire logic                  rst,
	input wire logic [7:0]            regAddr,
	input wire logic [31:0]           regWrData,
	input wire logic                  regWr,
	input wire logic                  regRd,
	input wire logic [31:0]           regRdData,
	input wire logic                  debugPinIn,
	input wire logic                  debugPinOut,
	input wire logic                  debugPinOe,
	input wire logic                  flashSecured,
	input wire logic                  coreStopped,
	input wire logic [HALT_SRC_N-1:0] haltEvents,
	input wire logic                  coreHalt,
	input wire logic                  resumeJump,
	input wire logic                  resumeNormal,
	input wire logic [31:0]           resumePc,
	input wire logic                  forceResetPulse,
	input wire logic                  haltAfterReset
);
	default clocking dc @(posedge clk); endclocking
	default disable iff (rst);

	////////////////////////////////////////////////////////////////
	// pin seen low on the first two edges after reset
	sequence pinLowEntry;
		$fell(rst) && !debugPinIn ##1 !debugPinIn;
	endsequence
	// write of the force bit in the second config word
	sequence forceWrite;
		regWr && regAddr == 8'h04 && regWrData[0];
	endsequence

	////////////////////////////////////////////////////////////////
	halt_entry_a: assert property (pinLowEntry |-> ##[1:2] coreHalt)
		else $error("no halt after reset with pin low");
	normal_entry_a: assert property ($fell(rst) && debugPinIn |-> !coreHalt [*4])
		else $error("halt after reset with pin high");
	unmapped_read_a: assert property (regRd && !(regAddr inside {8'h00, 8'h04, 8'h08})
		|=> regRdData == 32'h0) else $error("unmapped read not zero");
	force_pulse_a: assert property (forceWrite |=> forceResetPulse ##1 !forceResetPulse)
		else $error("force reset pulse wrong");
	halt_bit_a: assert property (regWr && regAddr == 8'h04
		|=> haltAfterReset == $past(regWrData[1])) else $error("halt after reset bit wrong");
	one_pulse_a: assert property ($rose(debugPinOe) && debugPinOut |=> ##[0:3] !debugPinOe)
		else $error("speed-up pulse too long");
	zero_low_a: assert property ($rose(debugPinOe) && !debugPinOut
		|-> (debugPinOe && !debugPinOut) [*8]) else $error("sent zero low too short");
	zero_release_a: assert property ($fell(debugPinOe) |-> $past(debugPinOut))
		else $error("pin released without high drive");
	rx_quiet_a: assert property ($fell(debugPinIn) && !debugPinOe |-> !debugPinOe [*3])
		else $error("device drives pin at host edge");
	resume_excl_a: assert property (!(resumeJump && resumeNormal))
		else $error("both resume kinds at once");
	jump_pulse_a: assert property (resumeJump |=> !resumeJump)
		else $error("resume jump longer than one cycle");
endmodule : single_wire_debug_link_properties

bind single_wire_debug_link single_wire_debug_link_properties #(
	.ALT_DIV(ALT_DIV), .HALT_SRC_N(HALT_SRC_N)
) u_props (
	.clk(clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
	.regRd(regRd), .regRdData(regRdData), .debugPinIn(debugPinIn),
	.debugPinOut(debugPinOut), .debugPinOe(debugPinOe), .flashSecured(flashSecured),
	.coreStopped(coreStopped), .haltEvents(haltEvents), .coreHalt(coreHalt),
	.resumeJump(resumeJump), .resumeNormal(resumeNormal), .resumePc(resumePc),
	.forceResetPulse(forceResetPulse), .haltAfterReset(haltAfterReset)
);

`default_nettype wire

// file: sim/tb_top.sv
/* Self-checking bench for single_wire_debug_link with a host pod model.
   Assumes the package constants and a pull-up on the debug wire. */
`timescale 1ns/1ps
`default_nettype none

`define CHECK_EQ(got, exp) begin tests_run++; if ((got) !== (exp)) begin failures++; \
	$display("wrong value at %0t: got %0h expected %0h", $time, (got), (exp)); end end

module tb_top;
	logic            clk = 1'b0;
	logic            rst = 1'b1;
	logic [7:0]      regAddr = 8'h00;
	logic [31:0]     regWrData = 32'h0;
	logic            regWr = 1'b0;
	logic            regRd = 1'b0;
	logic            flashSecured = 1'b0;
	logic            coreStopped = 1'b0;
	logic [2:0]      haltEvents = 3'h0;
	wire logic [31:0] regRdData, resumePc;
	wire logic       debugPinOut, debugPinOe, coreHalt, resumeJump, resumeNormal;
	wire logic       forceResetPulse, haltAfterReset, hostOe, hostOut, pin;
	int              failures = 0;
	int              tests_run = 0;
	int              jumps = 0, normals = 0, forces = 0, clashes = 0;
	logic [7:0]      ext;
	logic [31:0]     rd;

	always #2.5 clk = ~clk;

	// wire level from both drivers, pull-up otherwise
	assign pin = debugPinOe ? debugPinOut : (hostOe ? hostOut : 1'b1);

	always @(posedge clk) begin
		jumps += resumeJump;
		normals += resumeNormal;
		forces += forceResetPulse;
		clashes += (hostOe && debugPinOe && hostOut != debugPinOut);
	end

	single_wire_debug_link #(.ALT_DIV(4), .HALT_SRC_N(3)) u_dut (
		.clk(clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
		.regRd(regRd), .regRdData(regRdData), .debugPinIn(pin), .debugPinOut(debugPinOut),
		.debugPinOe(debugPinOe), .flashSecured(flashSecured), .coreStopped(coreStopped),
		.haltEvents(haltEvents), .coreHalt(coreHalt), .resumeJump(resumeJump),
		.resumeNormal(resumeNormal), .resumePc(resumePc),
		.forceResetPulse(forceResetPulse), .haltAfterReset(haltAfterReset)
	);
	debug_host_pod u_host (.clk(clk), .pin(pin), .hostOe(hostOe), .hostOut(hostOut));

	////////////////////////////////////////////////////////////////
	task automatic finish_test();
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : finish_test

	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		regAddr <= a;
		regWrData <= d;
		regWr <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
		@(posedge clk);
	endtask : reg_wr

	task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		@(posedge clk);
		d = regRdData;
	endtask : reg_rd

	task automatic read_ext(output logic [7:0] v);
		u_host.send_byte(debug_link_pkg::CMD_READ_EXT);
		u_host.recv_byte(v);
	endtask : read_ext

	task automatic do_reset(input logic pinLow);
		rst <= 1'b1;
		u_host.drive(pinLow, 1'b0);
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		u_host.drive(1'b0, 1'b1);
		u_host.div = pinLow ? 1 : 4;
		repeat (4) @(posedge clk);
	endtask : do_reset

	////////////////////////////////////////////////////////////////
	// reset into halt, halt source, plain resume
	task automatic t_halt_entry();
		int n;
		do_reset(1'b1);
		`CHECK_EQ(coreHalt, 1'b1)
		read_ext(ext);
		`CHECK_EQ(ext[3:0], 4'h7)
		reg_rd(8'h00, rd);
		`CHECK_EQ(rd[27:24], debug_link_pkg::HALT_CODE_RESET)
		reg_rd(8'h00, rd);
		`CHECK_EQ(rd, 32'h0)
		haltEvents <= 3'h6;
		@(posedge clk);
		haltEvents <= 3'h0;
		repeat (3) @(posedge clk);
		reg_rd(8'h00, rd);
		`CHECK_EQ(rd[27:24], 4'h3)
		n = normals;
		u_host.send_byte(debug_link_pkg::CMD_RESUME);
		repeat (20) @(posedge clk);
		`CHECK_EQ(normals - n, 1)
		read_ext(ext);
		`CHECK_EQ(ext[2], 1'b0)
	endtask : t_halt_entry

	task automatic t_pc_resume();
		int j;
		do_reset(1'b1);
		reg_rd(8'h00, rd);
		u_host.send_byte(debug_link_pkg::CMD_WRITE_PC);
		u_host.send_word(32'hA5C3_0F96);
		j = jumps;
		u_host.send_byte(debug_link_pkg::CMD_RESUME);
		repeat (20) @(posedge clk);
		`CHECK_EQ(jumps - j, 1)
		`CHECK_EQ(resumePc, 32'hA5C3_0F96)
		reg_rd(8'h08, rd);
		`CHECK_EQ(rd, 32'hA5C3_0F96)
		u_host.send_byte(debug_link_pkg::CMD_BACKGROUND);
		repeat (20) @(posedge clk);
		`CHECK_EQ(coreHalt, 1'b1)
		u_host.send_byte(debug_link_pkg::CMD_RESUME);
		repeat (20) @(posedge clk);
		reg_rd(8'h00, rd);
		`CHECK_EQ(rd[27:24], 4'h0)
	endtask : t_pc_resume

	// secured halt, forced reset with pin high
	task automatic t_secured();
		int r;
		flashSecured <= 1'b1;
		do_reset(1'b1);
		r = jumps + normals;
		u_host.send_byte(debug_link_pkg::CMD_RESUME);
		repeat (20) @(posedge clk);
		`CHECK_EQ(jumps + normals, r)
		read_ext(ext);
		`CHECK_EQ(ext[6:4], {debug_link_pkg::STAT_ILLEGAL, 1'b1})
		r = forces;
		reg_wr(8'h04, 32'h1);
		repeat (2) @(posedge clk);
		`CHECK_EQ(forces - r, 1)
		reg_rd(8'h04, rd);
		`CHECK_EQ(rd, 32'h0)
		do_reset(1'b0);
		`CHECK_EQ(coreHalt, 1'b0)
		flashSecured <= 1'b0;
	endtask : t_secured

	// normal mode on the alternate clock, select set serially
	task automatic t_normal();
		coreStopped <= 1'b1;
		read_ext(ext);
		`CHECK_EQ(ext[3:0], 4'h8)
		coreStopped <= 1'b0;
		reg_wr(8'hF3, 32'hFFFF_FFFF);
		reg_rd(8'hF3, rd);
		`CHECK_EQ(rd, 32'h0)
		reg_wr(8'h04, 32'h2);
		`CHECK_EQ(haltAfterReset, 1'b1)
		reg_rd(8'h04, rd);
		`CHECK_EQ(rd, 32'h2)
		reg_wr(8'h04, 32'h0);
		u_host.send_byte(debug_link_pkg::CMD_WRITE_EXT);
		u_host.send_byte(8'h03);
		u_host.div = 1;
		repeat (20) @(posedge clk);
		read_ext(ext);
		`CHECK_EQ(ext[1:0], 2'h3)
	endtask : t_normal

	// partial command, then a gap past the limit
	task automatic t_timeout();
		u_host.send_bit(1'b0);
		u_host.send_bit(1'b1);
		repeat (600) @(posedge clk);
		read_ext(ext);
		`CHECK_EQ(ext[6:5], debug_link_pkg::STAT_TIMEOUT)
	endtask : t_timeout

	// long low request, answer timed from release
	task automatic t_sync();
		int c;
		u_host.drive(1'b1, 1'b0);
		repeat (140) @(posedge clk);
		u_host.drive(1'b1, 1'b1);
		@(posedge clk);
		u_host.drive(1'b0, 1'b1);
		c = 0;
		while (!(debugPinOe && debugPinOut) && c < 400) begin
			@(posedge clk);
			c++;
		end
		`CHECK_EQ(c > 126 && c < 134, 1'b1)
	endtask : t_sync

	////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		t_halt_entry();
		t_pc_resume();
		t_secured();
		t_normal();
		t_timeout();
		t_sync();
		`CHECK_EQ(clashes, 0)
		finish_test();
	end

	// cut a hang short
	initial begin
		#500000;
		failures++;
		finish_test();
	end
endmodule : tb_top

`default_nettype wire

// file: src/debug_link_pkg.sv
/*
 * Constants for the single-wire debug link: link timing counts, serial
 * command codes, status encodings, register offsets and field positions.
 * Assumes nothing; it holds definitions only.
 */
package debug_link_pkg;

	// link timing, counted in link-clock ticks except RESET_LOW_CYCLES, which counts bus clocks
	localparam int unsigned RESET_LOW_CYCLES = 2;    // bus clocks of low pin after reset
	localparam int unsigned BIT_TICKS        = 16;   // nominal bit length
	localparam int unsigned RX_SAMPLE_TICK   = 10;   // host-to-target sample point
	localparam int unsigned TX1_PULSE_TICK   = 7;    // speed-up pulse of a sent 1
	localparam int unsigned TX0_LOW_TICKS    = 13;   // low time of a sent 0
	localparam int unsigned TX_END_TICK      = 14;   // bit engine frees after this
	localparam int unsigned TIMEOUT_TICKS    = 512;  // gap between host falling edges
	localparam int unsigned SYNC_LOW_TICKS   = 128;  // host low time read as sync request
	localparam int unsigned SYNC_RESP_TICKS  = 128;  // low time of the sync answer

	// serial command codes
	localparam logic [7:0] CMD_RESUME     = 8'h08;
	localparam logic [7:0] CMD_BACKGROUND = 8'h90;
	localparam logic [7:0] CMD_READ_EXT   = 8'h2D;
	localparam logic [7:0] CMD_WRITE_EXT  = 8'h0D;
	localparam logic [7:0] CMD_READ_CSR   = 8'h2E;
	localparam logic [7:0] CMD_WRITE_PC   = 8'h4F;

	// command_status field values
	localparam logic [1:0] STAT_OK      = 2'h0;
	localparam logic [1:0] STAT_ILLEGAL = 2'h2;
	localparam logic [1:0] STAT_TIMEOUT = 2'h3;

	// extended_control_status byte layout
	localparam int unsigned EXT_ENABLE  = 0;
	localparam int unsigned EXT_CLKSEL  = 1;
	localparam int unsigned EXT_HALTED  = 2;
	localparam int unsigned EXT_STOPPED = 3;
	localparam int unsigned EXT_SECURED = 4;
	localparam int unsigned EXT_STAT_LO = 5;

	// halt source codes (higher value wins)
	localparam logic [3:0] HALT_CODE_BKGND = 4'h7;
	localparam logic [3:0] HALT_CODE_RESET = 4'h8;
	localparam int unsigned HALT_SRC_LO    = 24;

	// register port map
	localparam logic [7:0] ADDR_CONFIG_STATUS = 8'h00;
	localparam logic [7:0] ADDR_SECOND_CONFIG = 8'h04;
	localparam logic [7:0] ADDR_PC_VALUE      = 8'h08;
	localparam int unsigned SC_FORCE_RESET    = 0;
	localparam int unsigned SC_HALT_AFTER_RST = 1;

endpackage : debug_link_pkg

// file: src/single_wire_debug_link.sv
/*
 * Single-wire debug link controller: reset-into-halt entry, halt and run
 * status, link clock choice, bit-level serial engine on the debug pin,
 * timeout and a small software register port.
 * Assumes the pin inputs are synchronous to clk, an outside pull-up holds
 * the pin high when nobody drives it, and the core obeys coreHalt.
 */
// Our own choices: the address map and strobed register access.
//
// What this block does
// - pin low two clocks enters halted debug
// - resume jumps, except after a reset halt with no loaded counter, which resumes as reset
// - secured halt refuses all but basic commands
// - halted flag always reported, stopped flag only while not halted
// - halt source priority, cleared on read
// - resume clears halt source bits 26-24
// - host falling edge starts bits, msb first
// - nominal bit is sixteen link ticks
// - 512 ticks between edges times out
// - normal reset clears link clock select
// - halt reset sets link clock select
// - link clock select only serially writable
// - sync request answered with timed pulse
// - bit start then sample at ten
// - pin undriven while host sends
// - sent one gets pulse at seven
// - sent zero low thirteen, then high
// - force reset request makes reset event
// - undriven pin resets into normal mode
`timescale 1ns/1ps
`default_nettype none

module single_wire_debug_link #(
	parameter int unsigned ALT_DIV    = 4, // bus clocks per alternate link tick
	parameter int unsigned HALT_SRC_N = 3  // external halt sources
) (
	input  wire logic                  clk,
	input  wire logic                  rst,
	input  wire logic [7:0]            regAddr,
	input  wire logic [31:0]           regWrData,
	input  wire logic                  regWr,
	input  wire logic                  regRd,
	output logic      [31:0]           regRdData,
	input  wire logic                  debugPinIn,
	output logic                       debugPinOut,
	output logic                       debugPinOe,
	input  wire logic                  flashSecured,
	input  wire logic                  coreStopped,
	input  wire logic [HALT_SRC_N-1:0] haltEvents,
	output logic                       coreHalt,
	output logic                       resumeJump,
	output logic                       resumeNormal,
	output logic      [31:0]           resumePc,
	output logic                       forceResetPulse,
	output logic                       haltAfterReset
);

	initial begin
		if (ALT_DIV < 1 || ALT_DIV > 256)
			$error("ALT_DIV out of range");
		if (HALT_SRC_N < 1 || HALT_SRC_N > 6)
			$error("HALT_SRC_N out of range");
	end

	typedef enum logic [2:0] {S_IDLE, S_RX, S_LOWWATCH, S_TX, S_SYNC_HIGH, S_SYNC_RESP} link_state_t;

	link_state_t state_q;
	logic [7:0]  divCnt_q;
	logic        tick;
	logic        pinPrev_q;
	logic        startPending_q;
	logic [8:0]  cnt_q;
	logic [9:0]  gapCnt_q;
	logic        busy;
	logic        cmdPhase_q;
	logic [7:0]  cmd_q;
	logic [31:0] rxShift_q;
	logic [5:0]  rxBits_q;
	logic [5:0]  rxNeed_q;
	logic [7:0]  txShift_q;
	logic [3:0]  txBits_q;
	logic [1:0]  cmdStatus_q;
	logic        sampleBit;
	logic [31:0] rxWord;
	logic [7:0]  cmdByte;
	logic        unitDone;
	logic        pulseResume_q;
	logic        pulseBkgnd_q;
	logic        pulseWrExt_q;
	logic        pulseWrPc_q;
	logic        pulseRdCsr_q;
	logic [31:0] payload_q;
	logic        entryDone_q;
	logic [1:0]  entryLow_q;
	logic        entryHalt;
	logic        debugEnable_q;
	logic        clkSel_q;
	logic        halted_q;
	logic        resetHalt_q;
	logic        pcLoaded_q;
	logic [3:0]  haltSrc_q;
	logic [3:0]  haltSrcNew;
	logic [3:0]  haltSrcBase;
	logic [7:0]  extStatus;
	logic        restricted;
	logic        drvOe_d;
	logic        drvOut_d;

	//////////////////////////////////////////////////////////////////////////
	// link clock and edge detection

	// tick source
	// select set: every bus clock is a tick; clear: fixed alternate rate
	assign tick = clkSel_q || (divCnt_q == 8'(ALT_DIV - 1));

	always_ff @(posedge clk) begin
		if (rst || tick)
			divCnt_q <= 8'h00;
		else
			divCnt_q <= divCnt_q + 8'h01;
	end

	// host edge start
	// a host falling edge is held until the next tick (0-1 tick delay)
	// no start before the reset strap is read: a held-low pin is no edge
	always_ff @(posedge clk) begin
		if (rst) begin
			pinPrev_q      <= 1'b1;
			startPending_q <= 1'b0;
		end else begin
			pinPrev_q <= debugPinIn;
			if (entryDone_q && pinPrev_q && !debugPinIn && state_q == S_IDLE)
				startPending_q <= 1'b1;
			else if (tick)
				startPending_q <= 1'b0;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// serial protocol engine

	assign sampleBit  = debugPinIn;
	assign rxWord     = {rxShift_q[30:0], sampleBit};
	assign cmdByte    = rxWord[7:0];
	assign unitDone   = (rxBits_q + 6'h01) == rxNeed_q;
	assign busy       = state_q != S_IDLE || !cmdPhase_q || rxBits_q != 6'h00 || txBits_q != 4'h0;
	assign restricted = flashSecured || !debugEnable_q;

	localparam int unsigned EXT_ENABLE_I  = debug_link_pkg::EXT_ENABLE;
	localparam int unsigned EXT_CLKSEL_I  = debug_link_pkg::EXT_CLKSEL;
	localparam int unsigned EXT_HALTED_I  = debug_link_pkg::EXT_HALTED;
	localparam int unsigned EXT_STOPPED_I = debug_link_pkg::EXT_STOPPED;
	localparam int unsigned EXT_SECURED_I = debug_link_pkg::EXT_SECURED;
	localparam int unsigned EXT_STAT_I    = debug_link_pkg::EXT_STAT_LO;

	// extended_control_status as the host reads it
	always_comb begin
		extStatus                  = 8'h00;
		extStatus[EXT_ENABLE_I]    = debugEnable_q;
		extStatus[EXT_CLKSEL_I]    = clkSel_q;
		extStatus[EXT_HALTED_I]    = halted_q;
		extStatus[EXT_STOPPED_I]   = coreStopped && !halted_q;
		extStatus[EXT_SECURED_I]   = flashSecured;
		extStatus[EXT_STAT_I+:2]   = cmdStatus_q;
	end

	// bit timing, byte assembly and command decode
	always_ff @(posedge clk) begin
		pulseResume_q <= 1'b0;
		pulseBkgnd_q  <= 1'b0;
		pulseWrExt_q  <= 1'b0;
		pulseWrPc_q   <= 1'b0;
		pulseRdCsr_q  <= 1'b0;
		if (rst) begin
			state_q     <= S_IDLE;
			cnt_q       <= 9'h000;
			gapCnt_q    <= 10'h000;
			cmdPhase_q  <= 1'b1;
			cmd_q       <= 8'h00;
			rxShift_q   <= 32'h0000_0000;
			rxBits_q    <= 6'h00;
			rxNeed_q    <= 6'h08;
			txShift_q   <= 8'h00;
			txBits_q    <= 4'h0;
			cmdStatus_q <= debug_link_pkg::STAT_OK;
			payload_q   <= 32'h0000_0000;
		end else begin
			if (pinPrev_q && !debugPinIn)
				gapCnt_q <= 10'h000;
			else if (tick && busy)
				gapCnt_q <= gapCnt_q + 10'h001;
			if (tick && busy && gapCnt_q == 10'(debug_link_pkg::TIMEOUT_TICKS - 1)) begin
				state_q     <= S_IDLE;
				cmdPhase_q  <= 1'b1;
				rxBits_q    <= 6'h00;
				rxNeed_q    <= 6'h08;
				txBits_q    <= 4'h0;
				cmdStatus_q <= debug_link_pkg::STAT_TIMEOUT;
				gapCnt_q    <= 10'h000;
			end else if (tick) begin
				case (state_q)
					S_IDLE: begin
						if (startPending_q) begin
							cnt_q   <= 9'h001;
							state_q <= (txBits_q != 4'h0) ? S_TX : S_RX;
						end
					end
					S_RX: begin
						cnt_q <= cnt_q + 9'h001;
						if (cnt_q == 9'(debug_link_pkg::RX_SAMPLE_TICK)) begin
							state_q   <= sampleBit ? S_IDLE : S_LOWWATCH;
							rxShift_q <= rxWord;
							rxBits_q  <= unitDone ? 6'h00 : rxBits_q + 6'h01;
							if (unitDone && cmdPhase_q) begin
								cmd_q       <= cmdByte;
								cmdStatus_q <= debug_link_pkg::STAT_OK;
								case (cmdByte)
									debug_link_pkg::CMD_READ_EXT: begin
										txShift_q <= extStatus;
										txBits_q  <= 4'h8;
									end
									debug_link_pkg::CMD_WRITE_EXT: begin
										cmdPhase_q <= 1'b0;
										rxNeed_q   <= 6'h08;
									end
									debug_link_pkg::CMD_READ_CSR: begin
										if (restricted) begin
											cmdStatus_q <= debug_link_pkg::STAT_ILLEGAL;
										end else begin
											txShift_q    <= {4'h0, haltSrc_q};
											txBits_q     <= 4'h8;
											pulseRdCsr_q <= 1'b1;
										end
									end
									debug_link_pkg::CMD_WRITE_PC: begin
										if (restricted) begin
											cmdStatus_q <= debug_link_pkg::STAT_ILLEGAL;
										end else begin
											cmdPhase_q <= 1'b0;
											rxNeed_q   <= 6'h20;
										end
									end
									debug_link_pkg::CMD_RESUME: begin
										if (restricted || !halted_q)
											cmdStatus_q <= debug_link_pkg::STAT_ILLEGAL;
										else
											pulseResume_q <= 1'b1;
									end
									debug_link_pkg::CMD_BACKGROUND: begin
										if (restricted)
											cmdStatus_q <= debug_link_pkg::STAT_ILLEGAL;
										else
											pulseBkgnd_q <= 1'b1;
									end
									default: begin
										cmdStatus_q <= debug_link_pkg::STAT_ILLEGAL;
									end
								endcase
							end else if (unitDone) begin
								// data unit complete: apply it and wait for next command
								payload_q  <= rxWord;
								cmdPhase_q <= 1'b1;
								rxNeed_q   <= 6'h08;
								if (cmd_q == debug_link_pkg::CMD_WRITE_EXT)
									pulseWrExt_q <= 1'b1;
								else
									pulseWrPc_q <= 1'b1;
							end
						end
					end
					S_LOWWATCH: begin
						cnt_q <= cnt_q + 9'h001;
						if (sampleBit) begin
							state_q <= S_IDLE;
						end else if (cnt_q == 9'(debug_link_pkg::SYNC_LOW_TICKS)) begin
							state_q    <= S_SYNC_HIGH;
							cmdPhase_q <= 1'b1;
							rxBits_q   <= 6'h00;
							rxNeed_q   <= 6'h08;
							txBits_q   <= 4'h0;
						end
					end
					S_SYNC_HIGH: begin
						if (sampleBit) begin
							state_q <= S_SYNC_RESP;
							cnt_q   <= 9'h000;
						end
					end
					S_SYNC_RESP: begin
						cnt_q <= cnt_q + 9'h001;
						if (cnt_q == 9'(debug_link_pkg::SYNC_RESP_TICKS))
							state_q <= S_IDLE;
					end
					S_TX: begin
						cnt_q <= cnt_q + 9'h001;
						if (cnt_q == 9'(debug_link_pkg::TX_END_TICK)) begin
							state_q   <= S_IDLE;
							txShift_q <= {txShift_q[6:0], 1'b0};
							txBits_q  <= txBits_q - 4'h1;
						end
					end
					default: begin
						state_q <= S_IDLE;
					end
				endcase
			end
		end
	end

	// pin drive decode from the engine state
	always_comb begin
		drvOe_d  = 1'b0;
		drvOut_d = 1'b0;
		case (state_q)
			S_TX: begin
				if (!txShift_q[7]) begin
					drvOe_d  = cnt_q <= 9'(debug_link_pkg::TX0_LOW_TICKS);
					drvOut_d = cnt_q == 9'(debug_link_pkg::TX0_LOW_TICKS);
				end else begin
					drvOe_d  = cnt_q == 9'(debug_link_pkg::TX1_PULSE_TICK);
					drvOut_d = 1'b1;
				end
			end
			S_SYNC_RESP: begin
				drvOe_d  = 1'b1;
				drvOut_d = cnt_q == 9'(debug_link_pkg::SYNC_RESP_TICKS);
			end
			default: begin
				drvOe_d  = 1'b0;
				drvOut_d = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			debugPinOe  <= 1'b0;
			debugPinOut <= 1'b0;
		end else begin
			debugPinOe  <= drvOe_d;
			debugPinOut <= drvOut_d;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// reset entry and mode bits

	// strap after reset
	// pin sampled for two bus clocks after release; high means normal mode
	assign entryHalt = !entryDone_q && !debugPinIn
		&& (entryLow_q + 2'h1) == 2'(debug_link_pkg::RESET_LOW_CYCLES);

	always_ff @(posedge clk) begin
		if (rst) begin
			entryDone_q <= 1'b0;
			entryLow_q  <= 2'h0;
		end else if (!entryDone_q) begin
			if (debugPinIn || entryHalt)
				entryDone_q <= 1'b1;
			entryLow_q <= entryLow_q + 2'h1;
		end
	end

	// serial-only clock select
	// link clock select and enable change only by reset entry or serial write
	always_ff @(posedge clk) begin
		if (rst) begin
			debugEnable_q <= 1'b0;
			clkSel_q      <= 1'b0;
		end else if (entryHalt) begin
			debugEnable_q <= 1'b1;
			clkSel_q      <= 1'b1;
		end else if (pulseWrExt_q) begin
			debugEnable_q <= payload_q[EXT_ENABLE_I];
			clkSel_q      <= payload_q[EXT_CLKSEL_I];
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// core run control

	always_ff @(posedge clk) begin
		if (rst) begin
			halted_q     <= 1'b0;
			resetHalt_q  <= 1'b0;
			pcLoaded_q   <= 1'b0;
			resumePc     <= 32'h0000_0000;
			resumeJump   <= 1'b0;
			resumeNormal <= 1'b0;
		end else begin
			resumeJump   <= pulseResume_q && (pcLoaded_q || !resetHalt_q);
			resumeNormal <= pulseResume_q && !pcLoaded_q && resetHalt_q;
			if (pulseWrPc_q && halted_q) begin
				resumePc   <= payload_q;
				pcLoaded_q <= 1'b1;
			end
			if (entryHalt || pulseBkgnd_q || (debugEnable_q && haltEvents != '0)) begin
				halted_q <= 1'b1;
			end else if (pulseResume_q) begin
				halted_q    <= 1'b0;
				resetHalt_q <= 1'b0;
				pcLoaded_q  <= 1'b0;
			end
			if (entryHalt)
				resetHalt_q <= 1'b1;
		end
	end

	assign coreHalt = halted_q;

	// highest active source this cycle
	always_comb begin
		haltSrcNew = 4'h0;
		for (int i = 0; i < HALT_SRC_N; i++) begin
			if (haltEvents[i] && debugEnable_q)
				haltSrcNew = 4'(i + 1);
		end
		if (pulseBkgnd_q)
			haltSrcNew = debug_link_pkg::HALT_CODE_BKGND;
		if (entryHalt)
			haltSrcNew = debug_link_pkg::HALT_CODE_RESET;
	end

	// halt source clears
	// a new source wins over any clear arriving in the same cycle
	always_comb begin
		haltSrcBase = haltSrc_q;
		if (pulseRdCsr_q || (regRd && regAddr == debug_link_pkg::ADDR_CONFIG_STATUS))
			haltSrcBase = 4'h0;
		else if (pulseResume_q)
			haltSrcBase = {haltSrc_q[3], 3'h0};
	end

	always_ff @(posedge clk) begin
		if (rst)
			haltSrc_q <= 4'h0;
		else if (haltSrcNew > haltSrcBase)
			haltSrc_q <= haltSrcNew;
		else
			haltSrc_q <= haltSrcBase;
	end

	//////////////////////////////////////////////////////////////////////////
	// software register port

	always_ff @(posedge clk) begin
		if (rst) begin
			forceResetPulse <= 1'b0;
			haltAfterReset  <= 1'b0;
		end else begin
			forceResetPulse <= regWr && regAddr == debug_link_pkg::ADDR_SECOND_CONFIG
				&& regWrData[debug_link_pkg::SC_FORCE_RESET];
			if (regWr && regAddr == debug_link_pkg::ADDR_SECOND_CONFIG)
				haltAfterReset <= regWrData[debug_link_pkg::SC_HALT_AFTER_RST];
		end
	end

	// read data valid in the cycle after the read strobe only
	always_ff @(posedge clk) begin
		if (rst || !regRd) begin
			regRdData <= 32'h0000_0000;
		end else begin
			case (regAddr)
				debug_link_pkg::ADDR_CONFIG_STATUS:
					regRdData <= {4'h0, haltSrc_q, 24'h00_0000};
				debug_link_pkg::ADDR_SECOND_CONFIG:
					regRdData <= {30'h0000_0000, haltAfterReset, 1'b0};
				debug_link_pkg::ADDR_PC_VALUE:
					regRdData <= resumePc;
				default:
					regRdData <= 32'h0000_0000;
			endcase
		end
	end

endmodule : single_wire_debug_link

`default_nettype wire
